/* File: hw/alu_pkg.sv */
// package: opcodes, flag positions, cycle counts for the arithmetic unit
// Overview of operation
// [RQ1] add registers, optional carry, one cycle
// [RQ2] word plus immediate, flags with sign, two cycles
// [RQ3] subtract register or constant, one cycle
// [RQ4] subtract with carry, register or constant
// [RQ5] word minus immediate, two cycles
// [RQ6] conjunction with register or constant, Z N V
// [RQ7] disjunction with register or constant, Z N V
// [RQ8] exclusive disjunction of registers, Z N V
// [RQ9] bit inversion is ff minus value
// [RQ10] set bits by or, clear by and-not
// [RQ11] zero sign check ands register with itself
// [RQ12] products unsigned, signed, mixed into r1:r0
// [RQ13] unsigned fraction product shifted left one
// [RQ14] signed fraction product shifted left one
// [RQ15] arithmetic inverse is zero minus value
// [RQ16] plus or minus one, carry kept
// [RQ17] all ones load no flags; zero register
package alu_pkg;
  // operation codes
  typedef enum logic [4:0] {
    op_add          = 5'h00,
    op_add_carry    = 5'h01,
    op_word_plus    = 5'h02,
    op_sub          = 5'h03,
    op_sub_carry    = 5'h04,
    op_word_minus   = 5'h05,
    op_and          = 5'h06,
    op_or           = 5'h07,
    op_xor          = 5'h08,
    op_bit_inv      = 5'h09,
    op_arith_inv    = 5'h0a,
    op_set_bits     = 5'h0b,
    op_clear_bits   = 5'h0c,
    op_plus_one     = 5'h0d,
    op_minus_one    = 5'h0e,
    op_check        = 5'h0f,
    op_zero_reg     = 5'h10,
    op_all_ones     = 5'h11,
    op_mul_u        = 5'h12,
    op_mul_s        = 5'h13,
    op_mul_su       = 5'h14,
    op_unsigned_fraction_product_u       = 5'h15,
    op_unsigned_fraction_product_s       = 5'h16
  } alu_op_t;
  // flag bit positions in the status byte
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // reset values and cycle counts
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES    = 8'hff;
  localparam logic [7:0] ONE         = 8'h01;
  localparam int SINGLE_CYCLES = 1;
  localparam int DOUBLE_CYCLES = 2;
endpackage : alu_pkg

/* File: hw/byte_adder.sv */
// eight-bit adder/subtractor with carry, half carry and overflow
`timescale 1ns/1ns
module byte_adder
  import alu_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  output logic      [7:0] sum,
  output logic            cout,
  output logic            hout,
  output logic            vout
);
  logic [8:0] full;
  logic [4:0] low;
  // subtraction borrows: a - b - cin
  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      vout = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      vout = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
    end
    sum  = full[7:0];
    cout = full[8];
    hout = low[4];
  end
endmodule : byte_adder

/* File: hw/byte_multiplier.sv */
// eight by eight multiplier with signed, mixed and fraction modes
`timescale 1ns/1ns
module byte_multiplier
  import alu_pkg::*;
(
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic        a_signed,
  input  wire logic        b_signed,
  input  wire logic        fraction,
  output logic      [15:0] product,
  output logic             carry
);
  logic [15:0] a_ext;
  logic [15:0] b_ext;
  logic [15:0] raw;
  // sign extend per operand; the low sixteen bits of the extended product
  // are the result for every sign mix, then optional left shift
  always_comb begin
    a_ext = {{8{a_signed & a[7]}}, a};
    b_ext = {{8{b_signed & b[7]}}, b};
    raw   = a_ext * b_ext;
    carry = raw[15];
    product = fraction ? {raw[14:0], 1'b0} : raw; // RQ13 RQ14
  end
endmodule : byte_multiplier

/* File: hw/cpu_arith_logic_unit.sv */
// arithmetic and logic datapath with registered result and flags
`timescale 1ns/1ns
module cpu_arith_logic_unit
  import alu_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [4:0]  op,
  input  wire logic [7:0]  dest_in,
  input  wire logic [7:0]  dest_high_in,
  input  wire logic [7:0]  src_in,
  input  wire logic        use_constant,
  input  wire logic [7:0]  constant_in,
  input  wire logic        carry_in,
  output logic             busy,
  output logic             done,
  output logic [7:0]       result_low,
  output logic [7:0]       result_high,
  output logic             write_low,
  output logic             write_high,
  output logic             write_product,
  output logic [7:0]       flags,
  output logic [7:0]       flag_update
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    st_idle  = 2'b01,
    st_second = 2'b10
  } phase_t;

  // hold fields carry the first half of a two-cycle op
  typedef struct packed {
    phase_t     phase;
    logic       busy;
    logic       done;
    logic [7:0] result_low;
    logic [7:0] result_high;
    logic       write_low;
    logic       write_high;
    logic       write_product;
    logic [7:0] flags;
    logic [7:0] flag_update;
    logic [7:0] hold_high;
    logic       hold_carry;
    logic       hold_sub;
    logic       hold_mul;
    logic [7:0] hold_low;
  } state_t;

  // registered state and its next value
  state_t cur;
  state_t next_state;

  // ==========================================================
  // shared datapath
  logic [7:0]  operand;
  logic [7:0]  add_a;
  logic [7:0]  add_b;
  logic        add_cin;
  logic        add_sub;
  logic [7:0]  add_sum;
  logic        add_c;
  logic        add_h;
  logic        add_v;
  logic [15:0] product;
  logic        prod_c;
  logic        is_word;
  logic        op_known;

  // operand source, second word cycle, defined codes
  assign operand = use_constant ? constant_in : src_in;
  assign is_word = cur.phase == st_second && !cur.hold_mul;
  assign op_known = op <= op_unsigned_fraction_product_s; // undefined codes do nothing

  // one shared byte adder for every add and subtract
  byte_adder byte_adder_inst (
    .a    (add_a),
    .b    (add_b),
    .cin  (add_cin),
    .sub  (add_sub),
    .sum  (add_sum),
    .cout (add_c),
    .hout (add_h),
    .vout (add_v)
  );

  // multiplier with sign and shift selects from the code
  byte_multiplier byte_multiplier_inst (
    .a        (dest_in),
    .b        (src_in),
    .a_signed (op == op_mul_s || op == op_mul_su || op == op_unsigned_fraction_product_s),
    .b_signed (op == op_mul_s || op == op_unsigned_fraction_product_s),
    .fraction (op == op_unsigned_fraction_product_u || op == op_unsigned_fraction_product_s),
    .product  (product),
    .carry    (prod_c)
  );

  // adder operand steering; second word cycle works the high byte
  always_comb begin
    add_a   = dest_in;
    add_b   = operand;
    add_cin = 1'b0;
    add_sub = 1'b0;
    // high byte of a word op: held byte plus or minus the held carry
    if (is_word) begin
      add_a   = cur.hold_high;
      add_b   = 8'h00;
      add_cin = cur.hold_carry;
      add_sub = cur.hold_sub;
    end else begin
      // byte ops steer by code; the rest keep a plain add
      unique case (op)
        op_add_carry:  add_cin = carry_in;              // RQ1
        op_sub:        add_sub = 1'b1;                  // RQ3
        op_sub_carry: begin
          add_sub = 1'b1;
          add_cin = carry_in;                           // RQ4
        end
        op_word_minus: add_sub = 1'b1;                  // RQ5
        // arithmetic inverse: zero minus the register
        op_arith_inv: begin
          add_a   = 8'h00;
          add_b   = dest_in;
          add_sub = 1'b1;                               // RQ15
        end
        // step by one uses the constant one
        op_plus_one:   add_b = ONE;                     // RQ16
        op_minus_one: begin
          add_b   = ONE;
          add_sub = 1'b1;                               // RQ16
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // next state
  // one decode for every op; single ops answer at the next edge,
  // word ops park their low byte, product ops their whole result, in the hold fields
  always_comb begin
    logic [7:0] val;
    logic [7:0] upd;
    logic [7:0] f;
    logic       znv;
    val   = 8'h00;
    upd   = 8'h00;
    f     = 8'h00;
    znv   = 1'b0;
    next_state = cur;
    // pulses fall after one cycle unless raised again below
    next_state.done          = 1'b0;
    next_state.write_low     = 1'b0;
    next_state.write_high    = 1'b0;
    next_state.write_product = 1'b0;
    next_state.flag_update   = 8'h00;
    unique case (cur.phase)
      st_idle: begin
        // start is only looked at here, so a start while busy is lost
        if (start && op_known) begin
          unique case (op)
            // byte arithmetic: c z n v h
            op_add, op_add_carry, op_sub, op_sub_carry,
            op_arith_inv: begin
              val       = add_sum;                      // RQ1 RQ3 RQ4
              f[FLAG_C] = add_c;
              f[FLAG_H] = add_h;
              f[FLAG_V] = add_v;
              upd       = 8'h2f;                        // RQ15
            end
            // step by one: carry is left as it was
            op_plus_one, op_minus_one: begin
              val       = add_sum;
              f[FLAG_V] = add_v;
              upd       = 8'h0e;                        // RQ16
            end

            // logic ops: z and n, overflow cleared
            op_and, op_check: begin
              val = dest_in & (op == op_check ? dest_in : operand); // RQ6 RQ11
              znv = 1'b1;
            end
            // disjunction and set-bits share one path
            op_or, op_set_bits: begin
              val = dest_in | operand;                  // RQ7 RQ10
              znv = 1'b1;
            end
            // clear-bits: and with the inverted mask
            op_clear_bits: begin
              val = dest_in & (ALL_ONES - operand);     // RQ10
              znv = 1'b1;
            end
            // exclusive disjunction with register or constant
            op_xor: begin
              val = dest_in ^ operand;                  // RQ8
              znv = 1'b1;
            end
            // register clear gives zero, z set
            op_zero_reg: begin
              val = dest_in ^ dest_in;                  // RQ17
              znv = 1'b1;
            end

            // bit inversion always sets carry
            op_bit_inv: begin
              val       = ALL_ONES - dest_in;           // RQ9
              f[FLAG_C] = 1'b1;
              upd       = 8'h0f;
            end
            // all-ones load leaves every flag alone
            op_all_ones: val = ALL_ONES;                // RQ17

            // word ops: low byte now, high byte next cycle
            op_word_plus, op_word_minus: begin
              next_state.hold_low   = add_sum;          // RQ2 RQ5
              next_state.hold_carry = add_c;
              next_state.hold_sub   = op == op_word_minus;
              next_state.hold_high  = dest_high_in;
              next_state.hold_mul   = 1'b0;
              next_state.phase      = st_second;
              next_state.busy       = 1'b1;
            end
            // products: whole result now, written next cycle
            op_mul_u, op_mul_s, op_mul_su, op_unsigned_fraction_product_u, op_unsigned_fraction_product_s: begin
              next_state.hold_low   = product[7:0];     // RQ12
              next_state.hold_high  = product[15:8];
              next_state.hold_carry = prod_c;
              next_state.hold_mul   = 1'b1;
              next_state.phase      = st_second;
              next_state.busy       = 1'b1;
            end
            // every defined code is listed above
            default: ;
          endcase
          // single ops finish here: result, z and n, merged flags
          if (next_state.phase == st_idle) begin
            f[FLAG_Z] = val == 8'h00;
            f[FLAG_N] = val[7];
            if (znv) upd = 8'h0e;                       // RQ6 RQ7 RQ8
            next_state.result_low  = val;
            next_state.write_low   = 1'b1;
            next_state.done        = 1'b1;
            next_state.flag_update = upd;
            next_state.flags       = (cur.flags & ~upd) | (f & upd);
          end
        end
      end
      // second cycle of a two-cycle op; any start now is ignored
      st_second: begin
        if (cur.hold_mul) begin
          // product: z over all sixteen bits, c from the multiplier
          f[FLAG_C] = cur.hold_carry;                   // RQ12 RQ13 RQ14
          f[FLAG_Z] = {cur.hold_high, cur.hold_low} == 16'h0000;
          upd = 8'h03;
          next_state.write_product = 1'b1;
        end else begin
          // word: high byte takes the carry or borrow of the low byte
          f[FLAG_C] = add_c;                            // RQ2 RQ5
          f[FLAG_N] = add_sum[7];
          f[FLAG_V] = cur.hold_sub ? (cur.hold_high[7] & ~add_sum[7])
                                   : (~cur.hold_high[7] & add_sum[7]);
          f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
          f[FLAG_Z] = {add_sum, cur.hold_low} == 16'h0000;
          upd = 8'h1f;
          next_state.write_low = 1'b1;
        end
        next_state.result_low  = cur.hold_low;
        next_state.result_high = cur.hold_mul ? cur.hold_high : add_sum;
        next_state.write_high  = 1'b1;
        next_state.flag_update = upd;
        next_state.flags       = (cur.flags & ~upd) | (f & upd);
        next_state.done        = 1'b1;
        next_state.busy        = 1'b0;
        next_state.phase       = st_idle;
      end
      // an illegal phase code falls back to idle
      default: next_state.phase = st_idle;
    endcase
  end

  // ==========================================================
  // registers
  // reset clears everything, phase to idle, flags to their reset value
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur <= '{phase: st_idle, flags: FLAGS_RESET, default: '0};
    end else begin
      cur <= next_state;
    end
  end

  // ==========================================================
  // outputs, straight from the state flops
  assign busy          = cur.busy;
  assign done          = cur.done;
  assign result_low    = cur.result_low;
  assign result_high   = cur.result_high;
  assign write_low     = cur.write_low;
  assign write_high    = cur.write_high;
  assign write_product = cur.write_product;
  assign flags         = cur.flags;
  assign flag_update   = cur.flag_update;
endmodule : cpu_arith_logic_unit

/* File: verification/alu_monitor.sv */
// checker: timing, flag masks and results of the arithmetic unit
`timescale 1ns/1ns
module alu_monitor
  import alu_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [4:0]  op,
  input wire logic [7:0]  dest_in,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  result_low,
  input wire logic        write_product,
  input wire logic [7:0]  flag_update
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========
  // accepted requests by class
  logic go;
  logic mul;
  logic dbl;
  assign go  = start && !busy;
  assign mul = op inside {[5'h12:5'h16]};
  assign dbl = mul || op inside {op_word_plus, op_word_minus};
  // two-cycle answer: busy, then done
  sequence two_step;
    busy && !done ##1 done && !busy;
  endsequence
  // ==========
  // assertions
  AST_ONE_CYCLE: assert property (go && !dbl && op <= 5'h11 |=> done)
    else $error("single op not done in one cycle");
  AST_TWO_CYCLE: assert property (go && dbl |=> two_step)
    else $error("two cycle op timing wrong");
  AST_ARITH_MASK: assert property (go && op inside {op_add, op_add_carry,
    op_sub, op_sub_carry, op_arith_inv} |=> flag_update == 8'h2f)
    else $error("arith flag mask wrong");
  AST_WORD_MASK: assert property (go && op inside {op_word_plus,
    op_word_minus} |-> ##2 flag_update == 8'h1f)
    else $error("word flag mask wrong");
  AST_LOGIC_MASK: assert property (go && op inside {[5'h06:5'h08],
    [5'h0b:5'h10]} |=> flag_update == 8'h0e)
    else $error("logic flag mask wrong");
  AST_INVERT: assert property (go && op == op_bit_inv |=>
    result_low == ~$past(dest_in) && flag_update == 8'h0f)
    else $error("bit inversion wrong");
  AST_PRODUCT: assert property (go && mul |->
    ##2 write_product && flag_update == 8'h03)
    else $error("product write or mask wrong");
  AST_ONES: assert property (go && op == op_all_ones |=>
    result_low == 8'hff && flag_update == 8'h00)
    else $error("all ones load wrong");
  AST_CHECK_KEEP: assert property (go && op == op_check |=>
    result_low == $past(dest_in))
    else $error("zero sign check changed value");
endmodule : alu_monitor

bind cpu_arith_logic_unit alu_monitor alu_monitor_inst (
  .ref_clk(ref_clk), .reset(reset), .start(start), .op(op),
  .dest_in(dest_in), .busy(busy), .done(done),
  .result_low(result_low), .write_product(write_product),
  .flag_update(flag_update));

/* File: verification/alu_regfile_model.sv */
// register file model that takes the unit's write pulses
`timescale 1ns/1ns
module alu_regfile_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        write_low,
  input  wire logic        write_high,
  input  wire logic        write_product,
  input  wire logic [7:0]  result_low,
  input  wire logic [7:0]  result_high,
  output logic      [15:0] pair,
  output logic      [7:0]  writes
);
  // capture written bytes, count write cycles
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pair   <= 16'h0000;
      writes <= 8'h00;
    end else if (write_low || write_high || write_product) begin
      writes <= writes + 8'h01;
      if (write_low || write_product)
        pair[7:0] <= result_low;
      if (write_high || write_product)
        pair[15:8] <= result_high;
    end
  end
endmodule : alu_regfile_model

/* File: verification/cpu_arith_logic_unit_tb_top.sv */
// self-checking bench for the arithmetic unit
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  err_total++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
  end end
module cpu_arith_logic_unit_tb_top;
  import alu_pkg::*;
  logic        ref_clk, reset, start, use_constant, carry_in;
  logic [4:0]  op;
  logic [7:0]  dest_in, dest_high_in, src_in, constant_in;
  logic        busy, done, write_low, write_high, write_product;
  logic [7:0]  result_low, result_high, flags, flag_update, writes;
  logic [15:0] pair;
  int          err_total = 0, n_checks = 0, cycles = 0;
  cpu_arith_logic_unit cpu_arith_logic_unit_inst (.ref_clk, .reset,
    .start, .op, .dest_in, .dest_high_in, .src_in, .use_constant,
    .constant_in, .carry_in, .busy, .done, .result_low, .result_high,
    .write_low, .write_high, .write_product, .flags, .flag_update);
  alu_regfile_model alu_regfile_model_inst (.ref_clk, .reset, .write_low,
    .write_high, .write_product, .result_low, .result_high, .pair,
    .writes);
  // ==========
  // flags each operation may change
  function automatic logic [7:0] mask_of(alu_op_t o);
    case (o)
      op_add, op_add_carry, op_sub, op_sub_carry, op_arith_inv: return 8'h2f;
      op_word_plus, op_word_minus: return 8'h1f;
      op_bit_inv: return 8'h0f;
      op_all_ones: return 8'h00;
      op_mul_u, op_mul_s, op_mul_su, op_unsigned_fraction_product_u, op_unsigned_fraction_product_s: return 8'h03;
      default: return 8'h0e;
    endcase
  endfunction : mask_of
  // one operation; unused operand source gets the inverse
  task automatic run_op(input alu_op_t o, input logic [7:0] d, b,
    input logic [15:0] e, input logic [7:0] ef,
    input logic uc = 1'b0, ci = 1'b0, input logic [7:0] dh = 8'h00);
    logic [7:0] em;
    logic       dbl;
    em  = mask_of(o);
    dbl = em == 8'h1f || em == 8'h03;
    @(posedge ref_clk);
    start        <= 1'b1;
    op           <= o;
    dest_in      <= d;
    dest_high_in <= dh;
    src_in       <= uc ? ~b : b;
    constant_in  <= uc ? b : ~b;
    use_constant <= uc;
    carry_in     <= ci;
    @(posedge ref_clk);
    start <= 1'b0;
    if (dbl) begin
      #1;
      `CHK("busy", busy, 1'b1)
      @(posedge ref_clk);
    end
    #1;
    `CHK("done", done, 1'b1)
    `CHK("result_low", result_low, e[7:0])
    if (dbl)
      `CHK("result_high", result_high, e[15:8])
    `CHK("flag_update", flag_update, em)
    `CHK("flags", flags & em, ef)
  endtask : run_op
  // ==========
  // scenarios
  task automatic sc_add;
    run_op(op_add, 8'h0f, 8'h01, 16'h0010, 8'h20);
    run_op(op_add, 8'h7f, 8'h01, 16'h0080, 8'h2c);
    run_op(op_add_carry, 8'hff, 8'h00, 16'h0000, 8'h23, 1'b0, 1'b1);
  endtask : sc_add
  task automatic sc_sub;
    run_op(op_sub, 8'h10, 8'h01, 16'h000f, 8'h20);
    run_op(op_sub, 8'h10, 8'h20, 16'h00f0, 8'h05, 1'b1);
    run_op(op_sub_carry, 8'h00, 8'h00, 16'h00ff, 8'h25, 1'b0, 1'b1);
    run_op(op_sub_carry, 8'h80, 8'h00, 16'h007f, 8'h28, 1'b1, 1'b1);
  endtask : sc_sub
  task automatic sc_word;
    run_op(op_word_plus, 8'hff, 8'h01, 16'h0000, 8'h03, 1, 0, 8'hff);
    run_op(op_word_plus, 8'hff, 8'h01, 16'h8000, 8'h0c, 1, 0, 8'h7f);
    run_op(op_word_minus, 8'h00, 8'h01, 16'hffff, 8'h15, 1, 0);
    @(posedge ref_clk);
    #1;
    `CHK("pair", pair, 16'hffff)
  endtask : sc_word
  task automatic sc_logic;
    run_op(op_and, 8'hf0, 8'h0f, 16'h0000, 8'h02);
    run_op(op_and, 8'hff, 8'h81, 16'h0081, 8'h04, 1'b1);
    run_op(op_or, 8'h80, 8'h01, 16'h0081, 8'h04);
    run_op(op_or, 8'h00, 8'h00, 16'h0000, 8'h02, 1'b1);
    run_op(op_xor, 8'h5a, 8'h5a, 16'h0000, 8'h02);
    run_op(op_set_bits, 8'h01, 8'h80, 16'h0081, 8'h04, 1'b1);
    run_op(op_clear_bits, 8'hff, 8'h0f, 16'h00f0, 8'h04, 1'b1);
    run_op(op_check, 8'h80, 8'h00, 16'h0080, 8'h04);
    run_op(op_zero_reg, 8'h37, 8'h00, 16'h0000, 8'h02);
    run_op(op_all_ones, 8'h00, 8'h00, 16'h00ff, 8'h00);
  endtask : sc_logic
  task automatic sc_unary;
    run_op(op_bit_inv, 8'h00, 8'h00, 16'h00ff, 8'h05);
    run_op(op_plus_one, 8'h7f, 8'h00, 16'h0080, 8'h0c);
    `CHK("carry kept", flags[FLAG_C], 1'b1)
    run_op(op_arith_inv, 8'h01, 8'h00, 16'h00ff, 8'h25);
    run_op(op_arith_inv, 8'h80, 8'h00, 16'h0080, 8'h0d);
    run_op(op_arith_inv, 8'h00, 8'h00, 16'h0000, 8'h02);
    run_op(op_minus_one, 8'h01, 8'h00, 16'h0000, 8'h02);
    `CHK("carry kept", flags[FLAG_C], 1'b0)
  endtask : sc_unary
  task automatic sc_mul;
    run_op(op_mul_u, 8'hff, 8'hff, 16'hfe01, 8'h01);
    run_op(op_mul_u, 8'h00, 8'h55, 16'h0000, 8'h02);
    run_op(op_mul_s, 8'hff, 8'hff, 16'h0001, 8'h00);
    run_op(op_mul_su, 8'hff, 8'hff, 16'hff01, 8'h01);
    run_op(op_unsigned_fraction_product_u, 8'hff, 8'hff, 16'hfc02, 8'h01);
    run_op(op_unsigned_fraction_product_s, 8'hc0, 8'h40, 16'he000, 8'h01);
    run_op(op_unsigned_fraction_product_s, 8'h80, 8'h80, 16'h8000, 8'h00);
  endtask : sc_mul
  // start held through busy must not launch a second op
  task automatic sc_refuse;
    logic [7:0] w;
    @(posedge ref_clk);
    #1;
    w = writes;
    @(posedge ref_clk);
    start        <= 1'b1;
    op           <= op_mul_u;
    dest_in      <= 8'h10;
    src_in       <= 8'h10;
    use_constant <= 1'b0;
    @(posedge ref_clk);
    op <= op_all_ones;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    `CHK("product", {result_high, result_low}, 16'h0100)
    @(posedge ref_clk);
    #1;
    `CHK("refused", done, 1'b0)
    `CHK("writes", writes, w + 8'h01)
    `CHK("pair", pair, 16'h0100)
  endtask : sc_refuse
  // an undefined code must neither answer nor write
  task automatic sc_unknown;
    logic [7:0] w;
    @(posedge ref_clk);
    start <= 1'b1;
    op    <= 5'h1f;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    w = writes;
    `CHK("unknown done", done, 1'b0)
    `CHK("unknown mask", flag_update, 8'h00)
    @(posedge ref_clk);
    #1;
    `CHK("unknown writes", writes, w)
  endtask : sc_unknown
  // ==========
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    reset        = 1'b1;
    start        = 1'b0;
    op           = 5'h00;
    dest_in      = 8'h00;
    dest_high_in = 8'h00;
    src_in       = 8'h00;
    use_constant = 1'b0;
    constant_in  = 8'h00;
    carry_in     = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    sc_add();
    sc_sub();
    sc_word();
    sc_logic();
    sc_unary();
    sc_mul();
    sc_refuse();
    sc_unknown();
    report_and_stop();
  end
endmodule : cpu_arith_logic_unit_tb_top
